// ### src/uoe_defines.vh
/*
 * register offsets, field positions, reset values and timing counts
 * for the otg event and status block.
 * assumes a 50 MHz mclk and a plain byte-addressed register port.
 */
`ifndef UOE_DEFINES_VH
`define UOE_DEFINES_VH

// register byte offsets
`define UOE_OFS_FLAGS 8'h00
`define UOE_OFS_ENABLES 8'h04
`define UOE_OFS_STATUS 8'h08
`define UOE_OFS_LINECTL 8'h0C
`define UOE_OFS_IRQSTAT 8'h10
`define UOE_OFS_IRQMASK 8'h14

// event flag and enable bit positions
`define UOE_BIT_ID 7
`define UOE_BIT_MS 6
`define UOE_BIT_LSTABLE 5
`define UOE_BIT_ACTIVITY 4
`define UOE_BIT_SESSVAL 3
`define UOE_BIT_BVBUS 2
`define UOE_BIT_AVBUS 0

// implemented bits of the flag, enable and status registers
`define UOE_EVENT_MASK 8'hFD
`define UOE_STATUS_MASK 8'hAD

// line control field positions
`define UOE_BIT_DPPU 7
`define UOE_BIT_DMPU 6
`define UOE_BIT_DPPD 5
`define UOE_BIT_DMPD 4
`define UOE_BIT_VBUS_ON 3
`define UOE_BIT_OWNER 2
`define UOE_BIT_VBUS_CHG 1
`define UOE_BIT_VBUS_DIS 0

// reset values
`define UOE_RST_BYTE 8'h00

// system-level interrupt status bits
`define UOE_IRQ_OTG 0
`define UOE_IRQ_WIDTH 1

// timing: 1 ms at 50 MHz
`define UOE_MS_TIME_NS 1000000
`define UOE_CLK_PERIOD_NS 20
`define UOE_MS_CYCLES (`UOE_MS_TIME_NS / `UOE_CLK_PERIOD_NS)

`endif

// ### src/uoe_sync2.v
/*
 * two-flop synchroniser for a bundle of pin levels.
 * assumes the inputs are asynchronous to mclk.
 */
`timescale 1ns/1ps
module uoe_sync2 #(
    parameter WIDTH = 1
) (
    input wire mclk,
    input wire srst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta;

// first stage feeds only the second stage
always @(posedge mclk) begin
    if (srst) begin
        meta <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else begin
        meta <= async_in;
        sync_out <= meta;
    end
end

endmodule // uoe_sync2

// ### src/uoe_ms_timer.v
/*
 * free running 1 ms tick generator and line stability counter.
 * assumes a 50 MHz mclk; counts come from the shared defines header.
 */
`timescale 1ns/1ps
`include "uoe_defines.vh"
module uoe_ms_timer #(
    parameter [31:0] MS_CYCLES = `UOE_MS_CYCLES
) (
    input wire mclk,
    input wire srst,
    input wire [1:0] line_state,
    output reg ms_tick,
    output reg line_stable
);

reg [31:0] tick_count;
reg [31:0] stable_count;
reg [1:0] last_line;

// one-cycle pulse every MS_CYCLES cycles
always @(posedge mclk) begin
    if (srst) begin
        tick_count <= 32'h00000000;
        ms_tick <= 1'b0;
    end else if (tick_count == MS_CYCLES - 32'h00000001) begin
        tick_count <= 32'h00000000;
        ms_tick <= 1'b1;
    end else begin
        tick_count <= tick_count + 32'h00000001;
        ms_tick <= 1'b0;
    end
end

// stable goes high once the line has held for MS_CYCLES cycles
always @(posedge mclk) begin
    if (srst) begin
        last_line <= 2'h0;
        stable_count <= 32'h00000000;
        line_stable <= 1'b0;
    end else begin
        last_line <= line_state;
        if (line_state != last_line) begin
            stable_count <= 32'h00000000;
            line_stable <= 1'b0;
        end else if (stable_count < MS_CYCLES - 32'h00000001) begin
            stable_count <= stable_count + 32'h00000001;
        end else begin
            line_stable <= 1'b1;
        end
    end
end

endmodule // uoe_ms_timer

// ### src/uoe_otg_event_status.v
/*
 * otg event, status and line control logic of a full speed usb
 * controller: event flags, their enables, live status, pull control,
 * and a masked system interrupt output.
 * assumes pin inputs are asynchronous to mclk and that the register
 * port master follows one-cycle strobes with read data next cycle.
 */
`timescale 1ns/1ps
`include "uoe_defines.vh"

module uoe_otg_event_status #(
    parameter [31:0] MS_CYCLES = `UOE_MS_CYCLES
) (
    input wire mclk,
    input wire srst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire cable_id_pin,
    input wire session_valid_pin,
    input wire session_end_pin,
    input wire a_vbus_valid_pin,
    input wire single_ended_zero,
    input wire j_line_state,
    input wire wake_activity,
    input wire hw_dplus_pullup_en,
    input wire hw_dminus_pullup_en,
    input wire hw_dplus_pulldown_en,
    input wire hw_dminus_pulldown_en,
    output reg dplus_pullup_en,
    output reg dminus_pullup_en,
    output reg dplus_pulldown_en,
    output reg dminus_pulldown_en,
    output reg vbus_on,
    output reg vbus_charge_en,
    output reg vbus_discharge_en,
    output reg otg_irq,
    output reg sys_irq
);

// synchronised pin levels
wire [6:0] pins_sync;
wire cable_identity_state;
wire session_valid_state;
wire b_session_end_state;
wire a_vbus_valid_state;
wire se0_sync;
wire j_sync;
wire activity_sync;
wire ms_tick;
wire line_stable_state;

// registers
reg [7:0] otg_event_flags;
reg [7:0] otg_event_enables;
reg [7:0] otg_line_control;
reg [`UOE_IRQ_WIDTH-1:0] irq_status;
reg [`UOE_IRQ_WIDTH-1:0] irq_mask;

// previous samples for change detection
reg prev_id;
reg prev_sessval;
reg prev_sessend;
reg prev_stable;
reg [1:0] reported_line;
reg prev_activity;
reg seeded;
reg [1:0] seed_state;
reg [1:0] next_seed_state;

reg [7:0] hw_events;
reg [7:0] next_flags;
reg [7:0] status_byte;
reg [31:0] next_rdata;
reg otg_level;

// register strobes, decoded once
wire wr_flags;
wire wr_enables;
wire wr_linectl;
wire wr_irqmask;
wire rd_irqstat;

// pads a byte into a bus word, upper bits zero
function [31:0] uoe_word;
    input [7:0] b;
    begin
        uoe_word = {24'h000000, b};
    end
endfunction

// address match for a register strobe
function uoe_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
        uoe_hit = (addr == ofs);
    end
endfunction

// register strobes decoded once for all processes
assign wr_flags = reg_wr && uoe_hit(reg_addr, `UOE_OFS_FLAGS);
assign wr_enables = reg_wr && uoe_hit(reg_addr, `UOE_OFS_ENABLES);
assign wr_linectl = reg_wr && uoe_hit(reg_addr, `UOE_OFS_LINECTL);
assign wr_irqmask = reg_wr && uoe_hit(reg_addr, `UOE_OFS_IRQMASK);
assign rd_irqstat = reg_rd && uoe_hit(reg_addr, `UOE_OFS_IRQSTAT);

// two flops on every pin input
uoe_sync2 #(
    .WIDTH(7)
) u_sync (
    .mclk(mclk),
    .srst(srst),
    .async_in({cable_id_pin, session_valid_pin, session_end_pin,
        a_vbus_valid_pin, single_ended_zero, j_line_state,
        wake_activity}),
    .sync_out(pins_sync)
);

assign cable_identity_state = pins_sync[6];
assign session_valid_state = pins_sync[5];
assign b_session_end_state = pins_sync[4];
assign a_vbus_valid_state = pins_sync[3];
assign se0_sync = pins_sync[2];
assign j_sync = pins_sync[1];
assign activity_sync = pins_sync[0];

// 1 ms tick and line stability detector
uoe_ms_timer #(
    .MS_CYCLES(MS_CYCLES)
) u_timer (
    .mclk(mclk),
    .srst(srst),
    .line_state({se0_sync, j_sync}),
    .ms_tick(ms_tick),
    .line_stable(line_stable_state)
);

// start-up sequencer: change detection waits until the synchroniser
// and the history flops hold real pin levels, so that the reset value
// of the synchroniser is never taken for a pin change
localparam [1:0] SEED_FLUSH = 2'h0; // first stage filling
localparam [1:0] SEED_SYNC = 2'h1; // second stage filling
localparam [1:0] SEED_LOAD = 2'h2; // history takes real levels
localparam [1:0] SEED_RUN = 2'h3; // change detection live

// next start-up state
always @* begin
    next_seed_state = seed_state;
    case (seed_state)
        SEED_FLUSH: next_seed_state = SEED_SYNC;
        SEED_SYNC: next_seed_state = SEED_LOAD;
        SEED_LOAD: next_seed_state = SEED_RUN;
        SEED_RUN: next_seed_state = SEED_RUN;
        default: next_seed_state = SEED_FLUSH;
    endcase
end

// start-up state register, restarts with every reset
always @(posedge mclk) begin
    if (srst) begin
        seed_state <= SEED_FLUSH;
    end else begin
        seed_state <= next_seed_state;
    end
end

// live status byte; unimplemented bits stay zero
always @* begin
    status_byte = 8'h00;
    status_byte[`UOE_BIT_ID] = cable_identity_state;
    status_byte[`UOE_BIT_LSTABLE] = line_stable_state;
    status_byte[`UOE_BIT_SESSVAL] = session_valid_state;
    status_byte[`UOE_BIT_BVBUS] = b_session_end_state;
    status_byte[`UOE_BIT_AVBUS] = a_vbus_valid_state;
end

// hardware events for this cycle; all but the ms tick held off until inputs are seeded
always @* begin
    hw_events = 8'h00;
    if (seeded) begin
        hw_events[`UOE_BIT_ID] = cable_identity_state ^ prev_id;
        hw_events[`UOE_BIT_LSTABLE] = line_stable_state & ~prev_stable
            & ({se0_sync, j_sync} != reported_line);
        hw_events[`UOE_BIT_ACTIVITY] = activity_sync
            & ~prev_activity;
        hw_events[`UOE_BIT_SESSVAL] = prev_sessval
            & ~session_valid_state;
        hw_events[`UOE_BIT_BVBUS] = b_session_end_state
            ^ prev_sessend;
        hw_events[`UOE_BIT_AVBUS] = session_valid_state
            ^ prev_sessval;
    end
    hw_events[`UOE_BIT_MS] = ms_tick;
end

// write one clears, a set in the same cycle wins
always @* begin
    next_flags = otg_event_flags;
    if (wr_flags) begin
        next_flags = next_flags & ~reg_wdata[7:0];
    end
    next_flags = (next_flags | hw_events) & `UOE_EVENT_MASK;
end

// change detection history
always @(posedge mclk) begin
    if (srst) begin
        prev_id <= 1'b0;
        prev_sessval <= 1'b0;
        prev_sessend <= 1'b0;
        prev_stable <= 1'b0;
        prev_activity <= 1'b0;
        reported_line <= 2'h0;
        seeded <= 1'b0;
    end else begin
        prev_id <= cable_identity_state;
        prev_sessval <= session_valid_state;
        prev_sessend <= b_session_end_state;
        prev_stable <= line_stable_state;
        prev_activity <= activity_sync;
        seeded <= (next_seed_state == SEED_RUN);
        if (line_stable_state && !prev_stable) begin
            reported_line <= {se0_sync, j_sync};
        end
    end
end

// flag, enable and line control registers
always @(posedge mclk) begin
    if (srst) begin
        otg_event_flags <= `UOE_RST_BYTE;
        otg_event_enables <= `UOE_RST_BYTE;
        otg_line_control <= `UOE_RST_BYTE;
    end else begin
        otg_event_flags <= next_flags;
        if (wr_enables) begin
            otg_event_enables <= reg_wdata[7:0] & `UOE_EVENT_MASK;
        end
        if (wr_linectl) begin
            otg_line_control <= reg_wdata[7:0];
        end
    end
end

// otg request level from flags and enables
always @* begin
    otg_level = |(next_flags & otg_event_enables);
end

// system interrupt status, cleared by reading it
always @(posedge mclk) begin
    if (srst) begin
        irq_status <= {`UOE_IRQ_WIDTH{1'b0}};
        irq_mask <= {`UOE_IRQ_WIDTH{1'b0}};
    end else begin
        if (rd_irqstat) begin
            irq_status <= {`UOE_IRQ_WIDTH{1'b0}} | otg_level;
        end else begin
            irq_status <= irq_status | otg_level;
        end
        if (wr_irqmask) begin
            irq_mask <= reg_wdata[`UOE_IRQ_WIDTH-1:0];
        end
    end
end

// read mux; status registers ignore writes
always @* begin
    case (reg_addr)
        `UOE_OFS_FLAGS: next_rdata = uoe_word(otg_event_flags);
        `UOE_OFS_ENABLES: next_rdata = uoe_word(otg_event_enables);
        `UOE_OFS_STATUS: next_rdata = uoe_word(status_byte);
        `UOE_OFS_LINECTL: next_rdata = uoe_word(otg_line_control);
        `UOE_OFS_IRQSTAT: next_rdata = {31'h00000000, irq_status};
        `UOE_OFS_IRQMASK: next_rdata = {31'h00000000, irq_mask};
        default: next_rdata = 32'h00000000;
    endcase
end

// read data stands only in the cycle after the strobe
always @(posedge mclk) begin
    if (srst) begin
        reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
        reg_rdata <= next_rdata;
    end else begin
        reg_rdata <= 32'h00000000;
    end
end

// registered outputs: pull control owner, vbus control, interrupts
always @(posedge mclk) begin
    if (srst) begin
        dplus_pullup_en <= 1'b0;
        dminus_pullup_en <= 1'b0;
        dplus_pulldown_en <= 1'b0;
        dminus_pulldown_en <= 1'b0;
        vbus_on <= 1'b0;
        vbus_charge_en <= 1'b0;
        vbus_discharge_en <= 1'b0;
        otg_irq <= 1'b0;
        sys_irq <= 1'b0;
    end else begin
        if (otg_line_control[`UOE_BIT_OWNER]) begin
            dplus_pullup_en <= otg_line_control[`UOE_BIT_DPPU];
            dminus_pullup_en <= otg_line_control[`UOE_BIT_DMPU];
            dplus_pulldown_en <= otg_line_control[`UOE_BIT_DPPD];
            dminus_pulldown_en <= otg_line_control[`UOE_BIT_DMPD];
        end else begin
            dplus_pullup_en <= hw_dplus_pullup_en;
            dminus_pullup_en <= hw_dminus_pullup_en;
            dplus_pulldown_en <= hw_dplus_pulldown_en;
            dminus_pulldown_en <= hw_dminus_pulldown_en;
        end
        vbus_on <= otg_line_control[`UOE_BIT_VBUS_ON];
        vbus_charge_en <= otg_line_control[`UOE_BIT_VBUS_CHG];
        vbus_discharge_en <= otg_line_control[`UOE_BIT_VBUS_DIS];
        otg_irq <= otg_level;
        sys_irq <= |((irq_status | otg_level) & irq_mask);
    end
end

endmodule // uoe_otg_event_status

// ### testbench/uoe_usb_partner.sv
/* far side model: cable, transceiver line levels and vbus comparators.
   assumes the bench hands it the wanted pin levels at a clock edge. */
`timescale 1ns/1ps
module uoe_usb_partner (
    input wire mclk,
    input wire [6:0] pin_cmd,
    output reg cable_id_pin,
    output reg session_valid_pin,
    output reg session_end_pin,
    output reg a_vbus_valid_pin,
    output reg single_ended_zero,
    output reg j_line_state,
    output reg wake_activity
);
    // no cable at power up, comparators low, line idle
    initial begin
        {wake_activity, j_line_state, single_ended_zero, a_vbus_valid_pin,
            session_end_pin, session_valid_pin, cable_id_pin} = 7'h01;
    end
    // levels move one edge after the command, like a slow cable
    always @(posedge mclk) begin
        {wake_activity, j_line_state, single_ended_zero, a_vbus_valid_pin,
            session_end_pin, session_valid_pin, cable_id_pin} <= pin_cmd;
    end
endmodule // uoe_usb_partner

// ### testbench/uoe_otg_event_status_asserts.sv
/* port assertions of the otg event block.
   assumes one clock mclk and srst synchronous, active high. */
`timescale 1ns/1ps
module uoe_evt_chk #(
    parameter [31:0] MS_CYCLES = 32'd50000
) (
    input wire mclk,
    input wire srst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire dplus_pullup_en,
    input wire dminus_pulldown_en,
    input wire vbus_on,
    input wire vbus_charge_en,
    input wire vbus_discharge_en,
    input wire otg_irq,
    input wire sys_irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    wire ctl_wr = reg_wr && reg_addr == 8'h0C;
    wire [7:0] wd8 = reg_wdata[7:0];
    wire [2:0] ctl_vb = {reg_wdata[3], reg_wdata[1:0]};
    wire [1:0] ctl_pl = {reg_wdata[7], reg_wdata[4]};
    reg [7:0] en_q;
    reg mask_q;
    // shadow of the enables and the system mask
    always @(posedge mclk) begin
        if (srst) begin
            en_q <= 8'h00;
            mask_q <= 1'b0;
        end else if (reg_wr && reg_addr == 8'h04) begin
            en_q <= wd8 & 8'hFD;
        end else if (reg_wr && reg_addr == 8'h14) begin
            mask_q <= reg_wdata[0];
        end
    end
    sequence s_en_wb;
        reg_wr && reg_addr == 8'h04 ##1 reg_rd && reg_addr == 8'h04;
    endsequence
    sequence s_ctl_wb;
        ctl_wr ##1 reg_rd && reg_addr == 8'h0C;
    endsequence
    sequence s_ctl_settle;
        ctl_wr ##1 (!ctl_wr) [*2];
    endsequence
    upper_zero_a: assert property (
        reg_rdata[31:8] == 24'h0
        && (!reg_rdata[1] || $past(reg_addr) == 8'h0C))
        else $error("reserved read bits set");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    unmapped_zero_a: assert property (
        reg_rd && reg_addr > 8'h14 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    en_readback_a: assert property (
        s_en_wb |=> reg_rdata == {24'h0, $past(wd8, 2) & 8'hFD})
        else $error("enable readback wrong");
    ctl_readback_a: assert property (
        s_ctl_wb |=> reg_rdata == {24'h0, $past(wd8, 2)})
        else $error("line control readback wrong");
    vbus_copy_a: assert property (s_ctl_settle |->
        {vbus_on, vbus_charge_en, vbus_discharge_en} == $past(ctl_vb, 2))
        else $error("vbus outputs differ from control");
    pull_sw_a: assert property (
        s_ctl_settle and (reg_wdata[2] ##2 1'b1) |->
        {dplus_pullup_en, dminus_pulldown_en} == $past(ctl_pl, 2))
        else $error("software pulls not applied");
    irq_gate_a: assert property ($past(en_q) == 8'h00 |-> !otg_irq)
        else $error("irq with all enables clear");
    sys_gate_a: assert property (!$past(mask_q) |-> !sys_irq)
        else $error("system irq while masked");
endmodule // uoe_evt_chk
bind uoe_otg_event_status uoe_evt_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dplus_pullup_en(dplus_pullup_en),
    .dminus_pulldown_en(dminus_pulldown_en), .vbus_on(vbus_on),
    .vbus_charge_en(vbus_charge_en), .vbus_discharge_en(vbus_discharge_en),
    .otg_irq(otg_irq), .sys_irq(sys_irq));

// ### testbench/uoe_otg_event_status_tb.sv
/* self-checking bench of the otg event block with random pin traffic.
   assumes the partner model and the bound checker are compiled too. */
`timescale 1ns/1ps
module uoe_otg_event_status_tb;
    localparam [31:0] MS = 32'd20;
    reg mclk = 1'b0;
    reg srst = 1'b1;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [6:0] pin_cmd = 7'h01;
    reg [3:0] hw_pull = 4'h0;
    wire [31:0] reg_rdata;
    wire cid, sv, se, av, se0, jst, wk, otg_irq, sys_irq;
    wire [3:0] pull;
    wire [2:0] vb;
    integer err_total = 0;
    integer compares = 0;
    integer cyc = 0;
    integer i;
    reg [31:0] seed = 32'd43961;
    reg [31:0] d, r;
    reg [7:0] ef;
    reg [6:0] old, n;
    uoe_usb_partner u_far (.mclk(mclk), .pin_cmd(pin_cmd),
        .cable_id_pin(cid), .session_valid_pin(sv), .session_end_pin(se),
        .a_vbus_valid_pin(av), .single_ended_zero(se0),
        .j_line_state(jst), .wake_activity(wk));
    uoe_otg_event_status #(.MS_CYCLES(MS)) u_dut (.mclk(mclk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cable_id_pin(cid),
        .session_valid_pin(sv), .session_end_pin(se), .a_vbus_valid_pin(av),
        .single_ended_zero(se0), .j_line_state(jst), .wake_activity(wk),
        .hw_dplus_pullup_en(hw_pull[3]), .hw_dminus_pullup_en(hw_pull[2]),
        .hw_dplus_pulldown_en(hw_pull[1]), .hw_dminus_pulldown_en(hw_pull[0]),
        .dplus_pullup_en(pull[3]), .dminus_pullup_en(pull[2]),
        .dplus_pulldown_en(pull[1]), .dminus_pulldown_en(pull[0]),
        .vbus_on(vb[2]), .vbus_charge_en(vb[1]), .vbus_discharge_en(vb[0]),
        .otg_irq(otg_irq), .sys_irq(sys_irq));
    // clock and hang guard
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 6000) begin
            err_total = err_total + 1;
            final_report;
        end
    end
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    // flags a pin change should latch, and the live status of pins
    function [7:0] exp_flags(input [6:0] o, input [6:0] v);
        exp_flags = {o[0] ^ v[0], 2'b00, ~o[6] & v[6], o[1] & ~v[1],
            o[2] ^ v[2], 1'b0, o[1] ^ v[1]};
    endfunction
    function [7:0] exp_stat(input [6:0] v);
        exp_stat = {v[0], 3'b000, v[1], v[2], 1'b0, v[3]};
    endfunction
    task wt(input integer k);
        repeat (k) @(posedge mclk);
    endtask
    task wr(input [7:0] a, input [31:0] v);
        begin
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= v;
            @(posedge mclk);
            reg_wr <= 1'b0;
            #1; // next strobe is raised in a later time step
        end
    endtask
    task rd(input [7:0] a, output [31:0] v);
        begin
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge mclk);
            reg_rd <= 1'b0;
            #1 v = reg_rdata;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("unexpected %s exp %h seen %h", nm, e, g);
            end
        end
    endtask
    task final_report;
        begin
            $display("compares %0d err_total %0d", compares, err_total);
            if (err_total == 0 && compares > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    initial begin
        wt(8);
        srst <= 1'b0;
        wt(4);
        rd(8'h04, r); chk("enables", 32'h0, r);
        rd(8'h0C, r); chk("line ctl", 32'h0, r);
        rd(8'h00, r); chk("flags", 32'h0, r & 32'hBD);
        rd(8'h08, r); chk("status", 32'h80, r);
        wr(8'h04, 32'hFFFFFFFF); rd(8'h04, r); chk("en", 32'hFD, r);
        wr(8'h08, 32'hFF); rd(8'h08, r); chk("st ro", 32'h80, r & 32'h8D);
        rd(8'h20, r); chk("unmapped", 32'h0, r);
        $display("test registers done");
        // tick spacing: clear just after a tick, look before and after next
        i = 0;
        r = 32'h0;
        while (r[6] !== 1'b1 && i < 40) begin
            rd(8'h00, r);
            i = i + 1;
        end
        wr(8'h00, 32'h40); wt(8);
        rd(8'h00, r); chk("tick early", 32'h0, r & 32'h40);
        wt(12); rd(8'h00, r); chk("tick", 32'h40, r & 32'h40);
        $display("test timer done");
        // line goes to j, then a short glitch back to the same state
        wr(8'h00, 32'hFD);
        pin_cmd[5] <= 1'b1; wt(6);
        rd(8'h08, r); chk("unstable", 32'h0, r & 32'h20);
        wt(MS + 4);
        rd(8'h08, r); chk("stable", 32'h20, r & 32'h20);
        rd(8'h00, r); chk("line flag", 32'h20, r & 32'h20);
        wr(8'h00, 32'h20); pin_cmd[5] <= 1'b0; wt(4);
        pin_cmd[5] <= 1'b1; wt(MS + 8);
        rd(8'h00, r); chk("same line", 32'h0, r & 32'h20);
        $display("test line done");
        // random pin moves, enables and hardware pulls
        for (i = 0; i < 24; i = i + 1) begin
            seed = xs(seed);
            d = seed;
            hw_pull <= d[3:0];
            wr(8'h04, d & 32'h9D);
            wr(8'h00, 32'hFD);
            old = pin_cmd;
            n = {d[12], old[5:4], d[11:8]};
            pin_cmd <= n;
            wt(8);
            ef = exp_flags(old, n);
            rd(8'h00, r); chk("ev flags", ef, r & 32'h9D);
            rd(8'h08, r); chk("status", exp_stat(n), r & 32'h8D);
            chk("irq", |(ef & d[7:0]), otg_irq);
            chk("hw pulls", d[3:0], pull);
        end
        $display("test random pins done");
        pin_cmd[0] <= ~pin_cmd[0]; wt(8);
        wr(8'h00, 32'h00); rd(8'h00, r); chk("w0", 32'h80, r & 32'h80);
        wr(8'h00, 32'h80); rd(8'h00, r); chk("w1c", 32'h0, r & 32'h80);
        pin_cmd[0] <= ~pin_cmd[0]; wr(8'h04, 32'h80); wt(8);
        chk("irq on", 32'h1, otg_irq);
        wr(8'h14, 32'h1); wt(3); chk("sys on", 32'h1, sys_irq);
        wr(8'h04, 32'h0); wt(3); chk("irq off", 32'h0, otg_irq);
        chk("sys sticky", 32'h1, sys_irq);
        rd(8'h10, r); chk("irq stat", 32'h1, r);
        wt(3); chk("sys clr", 32'h0, sys_irq);
        rd(8'h10, r); chk("irq stat clr", 32'h0, r);
        $display("test interrupts done");
        for (i = 0; i < 8; i = i + 1) begin
            seed = xs(seed);
            wr(8'h0C, seed | 32'h4);
            rd(8'h0C, r); chk("ctl", (seed & 32'hFF) | 32'h4, r);
            wt(2);
            chk("sw pulls", seed[7:4], pull);
            chk("vbus", {seed[3], seed[1:0]}, vb);
        end
        $display("test line control done");
        final_report;
    end
endmodule // uoe_otg_event_status_tb
